// ---- urx_defs.vh ----
`ifndef URX_DEFS_VH
`define URX_DEFS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define URX_ADDR_DATA     4'h0
`define URX_ADDR_STAT_A   4'h1
`define URX_ADDR_CTRL_B   4'h2
`define URX_ADDR_BAUD     4'h3
`define URX_ADDR_PORT     4'h4
`define URX_ADDR_IRQ_EN   4'h5
`define URX_ADDR_IRQ_CLR  4'h6
`define URX_ADDR_IRQ_STAT 4'h7
// ----------------------------------------
// Status A fields
// ----------------------------------------
`define URX_SA_RXC 7
`define URX_SA_FE  4
`define URX_SA_OR  3
// ----------------------------------------
// Control B fields
// ----------------------------------------
`define URX_CB_RECEIVER_ENABLE_BIT 4
`define URX_CB_NINE_BIT_CHAR_SEL 2
`define URX_CB_RX_NINTH_BIT 1
`define URX_CB_TX_NINTH_BIT 0
// ----------------------------------------
// Port fields
// ----------------------------------------
`define URX_PT_DIR 1
`define URX_PT_OUT 0
// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define URX_IRQ_RXC 0
`define URX_IRQ_FE  1
`define URX_IRQ_OR  2
// ----------------------------------------
// Sampling
// ----------------------------------------
`define URX_OVERSAMPLE 5'h10
`define URX_SMP_A      8
`define URX_SMP_B      9
`define URX_SMP_C      10
`define URX_BAUD_RST   8'h0_0
`endif

// ---- urx_receiver.v ----
`timescale 1ns/1ps
`default_nettype none
`include "urx_defs.vh"
module urx_receiver #(
   parameter DIV_W = 8
) (
   // Clock and reset
   input  wire        mclk,
   input  wire        reset,
   input  wire        clk_en,
   // Register port
   input  wire [3:0]  addr,
   input  wire [7:0]  wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [7:0]  rdata,
   // Pin zero of port d
   input  wire        pin_zero_in,
   output wire        pin_zero_out,
   output wire        pin_zero_oe_n,
   output wire        pin_zero_pullup,
   // Transmit side hand-off
   output reg  [7:0]  tx_data,
   output reg         tx_load,
   // Interrupt
   output wire        irq
);
// ----------------------------------------
// States
// ----------------------------------------
localparam [2:0] ST_IDLE  = 3'b001;
localparam [2:0] ST_START = 3'b010;
localparam [2:0] ST_BITS  = 3'b100;

// ----------------------------------------
// Majority vote
// ----------------------------------------
// Two of three decide, so one noisy sample inside the window is outvoted
function majority;
   input [2:0] s;
   begin
      majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   end
endfunction

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0]       ctrl_b_r;
reg [DIV_W-1:0] baud_divisor_r;
reg [1:0]       port_r;
reg [2:0]       irq_en_r;
reg [2:0]       irq_stat_r;
reg [7:0]       serial_data_reg_r;
reg             rx_complete_flag_r;
reg             frame_err_flag_r;
reg             ovr_vis_r;
reg             ovr_pend_r;
reg             pend_r;
reg [7:0]       pend_data_r;
reg             pend_b8_r;
reg             pend_fe_r;
reg             sync1_r;
reg             sync2_r;
reg [DIV_W-1:0] div_cnt_r;
reg [2:0]       state_r;
reg [3:0]       smp_cnt_r;
reg [3:0]       bit_cnt_r;
reg [2:0]       votes_r;
reg [8:0]       shift_r;

wire receiver_enable_bit = ctrl_b_r[`URX_CB_RECEIVER_ENABLE_BIT];
wire nine_bit_char_sel   = ctrl_b_r[`URX_CB_NINE_BIT_CHAR_SEL];
wire pin_zero_direction_bit = port_r[`URX_PT_DIR];
wire pin_zero_output_bit    = port_r[`URX_PT_OUT];

// ----------------------------------------
// Pin control
// ----------------------------------------
// Enabled receiver forces input; output bit then only steers the pull-up
assign pin_zero_oe_n   = receiver_enable_bit ? 1'b1 : ~pin_zero_direction_bit;
assign pin_zero_out    = pin_zero_output_bit;
assign pin_zero_pullup = pin_zero_output_bit & pin_zero_oe_n;

// ----------------------------------------
// Sample tick
// ----------------------------------------
wire tick = (div_cnt_r == {DIV_W{1'b0}});
// Sample count wraps to zero on sample sixteen, so a bit ends at smp_last + 1
wire [4:0] smp_per_bit = `URX_OVERSAMPLE;
wire [3:0] smp_last = smp_per_bit[3:0] - 4'h1;
wire [3:0] bits_total = nine_bit_char_sel ? 4'h9 : 4'h8;
// Samples 8 and 9 sit in the vote register, sample 10 is on the line now
wire bit_vote = majority({votes_r[1:0], sync2_r});
wire in_window = (smp_cnt_r >= `URX_SMP_A) && (smp_cnt_r <= `URX_SMP_C);
wire data_read = rd && (addr == `URX_ADDR_DATA);

reg char_done;
reg char_fe;
always @* begin
   char_done = 1'b0;
   char_fe   = 1'b0;
   if (clk_en && tick && state_r == ST_BITS && smp_cnt_r == `URX_SMP_C &&
       bit_cnt_r == bits_total) begin
      char_done = 1'b1;
      char_fe   = ~bit_vote;
   end
end
// Bits enter at the top: eight shifts leave the byte in [8:1], nine in [7:0]
wire [7:0] char_data = nine_bit_char_sel ? shift_r[7:0] : shift_r[8:1];
wire       char_b8   = shift_r[8];
// A lost byte stays in the shift register until the next frame overwrites it
wire       ovr_event = char_done && rx_complete_flag_r && !data_read;

// ----------------------------------------
// Receiver state machine
// ----------------------------------------
always @(posedge mclk or posedge reset) begin
   if (reset) begin
      // Chain resets to mark, the idle level, so reset never fakes a start edge
      sync1_r   <= 1'b1;
      sync2_r   <= 1'b1;
      div_cnt_r <= {DIV_W{1'b0}};
      state_r   <= ST_IDLE;
      smp_cnt_r <= 4'h0;
      bit_cnt_r <= 4'h0;
      votes_r   <= 3'h0;
      shift_r   <= 9'h0_00;
   end else if (clk_en) begin
      sync1_r <= pin_zero_in;
      sync2_r <= sync1_r;
      // A new divisor takes effect at the next reload, not mid-count
      div_cnt_r <= tick ? baud_divisor_r : div_cnt_r - 1'b1;
      if (!receiver_enable_bit) begin
         state_r <= ST_IDLE;
      end else if (tick) begin
         if (in_window)
            votes_r <= {votes_r[1:0], sync2_r};
         case (state_r)
            ST_IDLE: begin
               if (!sync2_r) begin
                  state_r   <= ST_START;
                  smp_cnt_r <= 4'h2;
               end
            end
            ST_START: begin
               smp_cnt_r <= smp_cnt_r + 1'b1;
               if (smp_cnt_r == `URX_SMP_C) begin
                  if (majority({votes_r[1:0], sync2_r})) begin
                     state_r <= ST_IDLE;
                  end
               end else if (smp_cnt_r == smp_last + 1'b1) begin
                  state_r   <= ST_BITS;
                  bit_cnt_r <= 4'h0;
                  smp_cnt_r <= 4'h1;
               end
            end
            ST_BITS: begin
               smp_cnt_r <= smp_cnt_r + 1'b1;
               if (smp_cnt_r == `URX_SMP_C) begin
                  if (bit_cnt_r == bits_total) begin
                     state_r <= ST_IDLE;
                  end else begin
                     // Decided bit enters at the top at once
                     shift_r   <= {majority({votes_r[1:0], sync2_r}), shift_r[8:1]};
                     bit_cnt_r <= bit_cnt_r + 1'b1;
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
end

// ----------------------------------------
// Receive data and flags
// ----------------------------------------
always @(posedge mclk or posedge reset) begin
   if (reset) begin
      serial_data_reg_r  <= 8'h0_0;
      rx_complete_flag_r <= 1'b0;
      frame_err_flag_r   <= 1'b0;
      ovr_vis_r          <= 1'b0;
      ovr_pend_r         <= 1'b0;
      pend_r             <= 1'b0;
      pend_data_r        <= 8'h0_0;
      pend_b8_r          <= 1'b0;
      pend_fe_r          <= 1'b0;
      ctrl_b_r           <= 8'h0_0;
   end else if (clk_en) begin
      if (wr && addr == `URX_ADDR_CTRL_B) begin
         ctrl_b_r[`URX_CB_RECEIVER_ENABLE_BIT] <= wdata[`URX_CB_RECEIVER_ENABLE_BIT];
         ctrl_b_r[`URX_CB_NINE_BIT_CHAR_SEL] <= wdata[`URX_CB_NINE_BIT_CHAR_SEL];
         ctrl_b_r[`URX_CB_TX_NINTH_BIT] <= wdata[`URX_CB_TX_NINTH_BIT];
      end
      if (data_read) begin
         // Overrun seen so far becomes visible with the read
         ovr_vis_r  <= ovr_pend_r | ovr_event;
         ovr_pend_r <= 1'b0;
         if (pend_r) begin
            serial_data_reg_r <= pend_data_r;
            ctrl_b_r[`URX_CB_RX_NINTH_BIT] <= pend_b8_r;
            frame_err_flag_r  <= pend_fe_r;
            pend_r            <= 1'b0;
         end else if (char_done) begin
            // A frame landing on the read cycle must still raise complete
            serial_data_reg_r  <= char_data;
            if (nine_bit_char_sel)
               ctrl_b_r[`URX_CB_RX_NINTH_BIT] <= char_b8;
            frame_err_flag_r   <= char_fe;
            rx_complete_flag_r <= 1'b1;
         end else begin
            rx_complete_flag_r <= 1'b0;
         end
      end else if (char_done) begin
         if (!rx_complete_flag_r) begin
            serial_data_reg_r  <= char_data;
            if (nine_bit_char_sel)
               ctrl_b_r[`URX_CB_RX_NINTH_BIT] <= char_b8;
            frame_err_flag_r   <= char_fe;
            rx_complete_flag_r <= 1'b1;
         end else begin
            ovr_pend_r <= 1'b1;
         end
      end
   end
end

// ----------------------------------------
// Software registers
// ----------------------------------------
wire [7:0] stat_a = {rx_complete_flag_r, 2'b00, frame_err_flag_r, ovr_vis_r, 3'b000};
wire [2:0] irq_set = {ovr_event | (char_done & rx_complete_flag_r & ~data_read),
                      char_done & char_fe, char_done};
wire       clr_wr  = wr && addr == `URX_ADDR_IRQ_CLR;

always @(posedge mclk or posedge reset) begin
   if (reset) begin
      baud_divisor_r <= {DIV_W{1'b0}};
      port_r         <= 2'b00;
      irq_en_r       <= 3'b000;
      irq_stat_r     <= 3'b000;
      rdata          <= 8'h0_0;
      tx_data        <= 8'h0_0;
      tx_load        <= 1'b0;
   end else if (clk_en) begin
      tx_load <= 1'b0;
      if (wr) begin
         case (addr)
            `URX_ADDR_DATA: begin
               tx_data <= wdata;
               tx_load <= 1'b1;
            end
            `URX_ADDR_BAUD:   baud_divisor_r <= wdata[DIV_W-1:0];
            `URX_ADDR_PORT:   port_r <= wdata[1:0];
            `URX_ADDR_IRQ_EN: irq_en_r <= wdata[2:0];
            default: ;
         endcase
      end
      // Hardware set wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~(clr_wr ? wdata[2:0] : 3'b000)) | irq_set;
      // Read data stands one cycle only; idle cycles return zero
      rdata <= 8'h0_0;
      if (rd) begin
         case (addr)
            `URX_ADDR_DATA:     rdata <= serial_data_reg_r;
            `URX_ADDR_STAT_A:   rdata <= stat_a;
            `URX_ADDR_CTRL_B:   rdata <= ctrl_b_r;
            `URX_ADDR_BAUD:     rdata <= baud_divisor_r;
            `URX_ADDR_PORT:     rdata <= {6'h00, port_r};
            `URX_ADDR_IRQ_EN:   rdata <= {5'h00, irq_en_r};
            `URX_ADDR_IRQ_STAT: rdata <= {5'h00, irq_stat_r};
            default:            rdata <= 8'h0_0;
         endcase
      end
   end
end

// ----------------------------------------
// Interrupt output
// ----------------------------------------
assign irq = |(irq_stat_r & irq_en_r);

endmodule // urx_receiver
`default_nettype wire

// ---- urx_line_drv.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Remote transmitter, LSB first, idles at mark
// ----------------------------------------
module urx_line_drv #(
   parameter int BIT_CLKS = 32
) (
   input  wire logic mclk,
   output var  logic line
);
   initial line = 1'b1;
   task automatic send(input logic [8:0] d, input int n, input logic stop);
      @(posedge mclk);
      line <= 1'b0;
      repeat (BIT_CLKS) @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         line <= d[i];
         repeat (BIT_CLKS) @(posedge mclk);
      end
      line <= stop;
      repeat (BIT_CLKS) @(posedge mclk);
      // One idle clock so back-to-back frames never assign twice at once
      line <= 1'b1;
      @(posedge mclk);
   endtask
   task automatic glitch(input int clks);
      @(posedge mclk);
      line <= 1'b0;
      repeat (clks) @(posedge mclk);
      line <= 1'b1;
   endtask
endmodule // urx_line_drv
`default_nettype wire

// ---- urx_receiver_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "urx_defs.vh"
module urx_chk (
   // Clock and register port
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic       clk_en,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   // Outputs under watch
   input wire logic [7:0] rdata,
   input wire logic       pin_zero_oe_n,
   input wire logic       pin_zero_pullup,
   input wire logic [7:0] tx_data,
   input wire logic       tx_load,
   input wire logic       irq
);
   // ----------------------------------------
   // Shadow of the writable control bits
   // ----------------------------------------
   logic [7:0] ctl_r, prt_r, ien_r;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctl_r <= 8'h00;
         prt_r <= 8'h00;
         ien_r <= 8'h00;
      end else if (clk_en && wr) begin
         if (addr == `URX_ADDR_CTRL_B) ctl_r <= wdata;
         if (addr == `URX_ADDR_PORT) prt_r <= wdata;
         if (addr == `URX_ADDR_IRQ_EN) ien_r <= wdata;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_dwr; clk_en && wr && addr == `URX_ADDR_DATA; endsequence
   sequence s_rd; clk_en && rd; endsequence
   a_tx_hand_off: assert property (s_dwr |=> tx_load && tx_data == $past(wdata))
      else $error("tx hand-off wrong");
   a_tx_load_cause: assert property (tx_load |-> $past(clk_en && wr && addr == 4'h0))
      else $error("tx load without write");
   a_tx_data_hold: assert property ($changed(tx_data) |-> tx_load)
      else $error("tx data moved alone");
   a_rdata_idle: assert property (rdata != 8'h00 |-> $past(clk_en && rd))
      else $error("read data outside slot");
   a_unmapped_read: assert property (s_rd ##0 addr[3] |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_gpio_drive: assert property (!ctl_r[`URX_CB_RECEIVER_ENABLE_BIT] |->
      pin_zero_oe_n == !prt_r[`URX_PT_DIR])
      else $error("pin drive wrong");
   a_rx_forces_in: assert property (ctl_r[`URX_CB_RECEIVER_ENABLE_BIT] |-> pin_zero_oe_n)
      else $error("pin driven while receiving");
   a_pullup_ctrl: assert property (pin_zero_pullup == (pin_zero_oe_n && prt_r[`URX_PT_OUT]))
      else $error("pull-up wrong");
   a_irq_masked: assert property (ien_r == 8'h00 |-> !irq)
      else $error("irq while masked");
endmodule // urx_chk
bind urx_receiver urx_chk i_urx_chk (.*);
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "urx_defs.vh"
module tb_top;
   logic       mclk, reset, wr, rd, clk_en;
   logic [3:0] addr;
   logic [7:0] wdata;
   wire  [7:0] rdata, tx_data;
   wire        line, pin, p_out, p_oe_n, p_pu, tx_load, irq;
   int         err_total = 0;
   int         num_checks = 0;
   // Pin level: design drives it only when its enable is low
   assign pin = !p_oe_n ? p_out : line;
   urx_receiver i_urx_receiver (.mclk(mclk), .reset(reset), .clk_en(clk_en), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_zero_in(pin),
      .pin_zero_out(p_out), .pin_zero_oe_n(p_oe_n), .pin_zero_pullup(p_pu),
      .tx_data(tx_data), .tx_load(tx_load), .irq(irq));
   urx_line_drv i_urx_line_drv (.mclk(mclk), .line(line));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // ----------------------------------------
   // Bus and check helpers
   // ----------------------------------------
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task conclude;
      if (err_total == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task wreg(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask
   task xreg(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task pins(input logic [7:0] e);
      chk({5'h00, p_pu, p_oe_n, p_out}, e);
   endtask
   task wait_irq;
      int n;
      for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge mclk);
      if (n == 2000) begin
         $display("MISMATCH %0t irq timeout", $time);
         err_total++;
         conclude();
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset_pins;
      pins(8'h02);
      xreg(4'hF, 8'h00);
      wreg(`URX_ADDR_PORT, 8'h03);
      pins(8'h01);
      wreg(`URX_ADDR_CTRL_B, 8'h10);
      pins(8'h07);
      wreg(`URX_ADDR_BAUD, 8'h01);
      wreg(`URX_ADDR_IRQ_EN, 8'h01);
   endtask
   task t_good_irq;
      i_urx_line_drv.send(9'h0A5, 8, 1'b1);
      wait_irq;
      xreg(`URX_ADDR_STAT_A, 8'h80);
      wreg(`URX_ADDR_IRQ_EN, 8'h00);
      chk({7'h00, irq}, 8'h00);
      wreg(`URX_ADDR_IRQ_EN, 8'h01);
      xreg(`URX_ADDR_IRQ_STAT, 8'h01);
      wreg(`URX_ADDR_IRQ_CLR, 8'h07);
      chk({7'h00, irq}, 8'h00);
      xreg(`URX_ADDR_DATA, 8'hA5);
      xreg(`URX_ADDR_STAT_A, 8'h00);
   endtask
   task t_noise;
      i_urx_line_drv.glitch(8);
      repeat (400) @(posedge mclk);
      xreg(`URX_ADDR_STAT_A, 8'h00);
   endtask
   task t_overrun;
      i_urx_line_drv.send(9'h011, 8, 1'b1);
      i_urx_line_drv.send(9'h022, 8, 1'b1);
      xreg(`URX_ADDR_STAT_A, 8'h80);
      xreg(`URX_ADDR_DATA, 8'h11);
      xreg(`URX_ADDR_STAT_A, 8'h08);
   endtask
   task t_nine_tx;
      wreg(`URX_ADDR_CTRL_B, 8'h14);
      i_urx_line_drv.send(9'h15A, 9, 1'b1);
      xreg(`URX_ADDR_CTRL_B, 8'h16);
      wreg(`URX_ADDR_CTRL_B, 8'h15);
      xreg(`URX_ADDR_CTRL_B, 8'h17);
      wreg(`URX_ADDR_DATA, 8'hC3);
      chk(tx_data, 8'hC3);
      chk({7'h00, tx_load}, 8'h01);
      xreg(`URX_ADDR_DATA, 8'h5A);
   endtask
   task t_frame_err;
      wreg(`URX_ADDR_CTRL_B, 8'h10);
      i_urx_line_drv.send(9'h03C, 8, 1'b0);
      xreg(`URX_ADDR_STAT_A, 8'h90);
      xreg(`URX_ADDR_DATA, 8'h3C);
   endtask
   task t_freeze;
      @(posedge mclk);
      clk_en <= 1'b0;
      wreg(`URX_ADDR_PORT, 8'h00);
      @(posedge mclk);
      clk_en <= 1'b1;
      pins(8'h07);
      xreg(`URX_ADDR_PORT, 8'h03);
   endtask
   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      t_reset_pins;
      t_good_irq;
      t_noise;
      t_overrun;
      t_nine_tx;
      t_frame_err;
      t_freeze;
      conclude;
   end
endmodule // tb_top
`default_nettype wire
